// ---- logic/charger_protection_consts.svh ----
`ifndef CHARGER_PROTECTION_CONSTS_SVH
`define CHARGER_PROTECTION_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CP_CLK_HZ 10000000
`define CP_THR_INTERVAL_MS 167
`define CP_THR_ON_US 1000
`define CP_DET_PERIOD_US 1000
`define CP_SHORT_TIMEOUT_US 30000
`define CP_TRICKLE_MIN 60

// ----------------------------------------
// register indices, byte address is four times
// ----------------------------------------
`define CP_IDX_CTRL 6'h07
`define CP_IDX_STATUS 6'h0B
`define CP_IDX_FAULT 6'h0D

// ----------------------------------------
// fields
// ----------------------------------------
`define CP_CTRL_THR_EN 0
`define CP_CTRL_CHG_EN 1
`define CP_CTRL_RESET 2'h2
`define CP_FLT_TSD 0
`define CP_FLT_WARN 1
`define CP_FLT_SHORT 2
`define CP_ST_ISO_LSB 0
`define CP_ST_CHG_LSB 2
`define CP_ST_THR_ACT 5
`define CP_ST_PACK_BAD 6
`define CP_ST_HOLD 7
`define CP_ST_NTC_100K 8
`define CP_ST_BETA_LSB 9

// ----------------------------------------
// charger status codes
// ----------------------------------------
`define CP_CHG_OFF 3'h0
`define CP_CHG_TRICKLE 3'h1
`define CP_CHG_FAST 3'h2
`define CP_CHG_DETECT 3'h3
`define CP_CHG_NO_BATT 3'h4
`define CP_CHG_SHORT 3'h5
`define CP_CHG_FAULT 3'h6

`endif

// ---- logic/charger_protection_pkg.sv ----
package charger_protection_pkg;

    // comparator levels from the analog side
    typedef struct packed {
        logic die_over_shutdown;
        logic die_below_falling;
        logic die_over_warning;
        logic input_valid;
        logic input_over_4v0;
        logic sys_below_bat;
        logic bat_over_dead;
        logic bat_over_sysreg;
        logic bat_over_2v5;
        logic bat_below_low;
        logic bat_over_high;
        logic bat_over_short;
        logic pack_cold;
        logic pack_hot;
    } cmp_t;

    typedef enum logic [1:0] {
        ISO_OFF,
        ISO_REGULATE,
        ISO_FULL
    } iso_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SINK,
        ST_SOURCE,
        ST_NO_BATT,
        ST_TRICKLE,
        ST_SHORT,
        ST_CHARGE,
        ST_FAULT
    } chg_state_t;

    // drive controls to the analog side
    typedef struct packed {
        logic charge_enable;
        logic trickle_enable;
        logic sink_enable;
        logic source_enable;
        logic thr_source;
    } drive_t;

endpackage : charger_protection_pkg

// ---- logic/charger_protection_control.sv ----
`timescale 1ns/100ps
`include "charger_protection_consts.svh"

module charger_protection_control #(
    parameter int unsigned DET_CYCLES =
        `CP_DET_PERIOD_US * (`CP_CLK_HZ / 1000000),
    parameter int unsigned SHORT_CYCLES =
        `CP_SHORT_TIMEOUT_US * (`CP_CLK_HZ / 1000000),
    parameter int unsigned THR_PERIOD_CYCLES =
        `CP_THR_INTERVAL_MS * (`CP_CLK_HZ / 1000),
    parameter int unsigned THR_ON_CYCLES =
        `CP_THR_ON_US * (`CP_CLK_HZ / 1000000),
    parameter longint unsigned TRICKLE_CYCLES =
        64'(`CP_TRICKLE_MIN) * 64'd60 * 64'(`CP_CLK_HZ),
    parameter bit NTC_100K = 1'b0,
    parameter logic [2:0] BETA_SEL = 3'h0
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // analog comparators, asynchronous
    input wire charger_protection_pkg::cmp_t cmp_i,
    // analog controls
    output charger_protection_pkg::drive_t drive_o,
    output charger_protection_pkg::iso_mode_t iso_mode_o
);

    localparam int CW = $bits(charger_protection_pkg::cmp_t);

    // ----------------------------------------
    // comparator synchronisers
    // ----------------------------------------
    logic [CW-1:0] sync1;
    logic [CW-1:0] sync2;
    logic [CW-1:0] sync3;
    logic [CW-1:0] filt;
    charger_protection_pkg::cmp_t cmp;

    always_ff @(posedge mclk_i)
    begin
        sync1 <= cmp_i;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // change counts once stages two and three agree
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            filt <= '0;
        else
            filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
    end

    assign cmp = filt;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic [31:0] rd_word;
    logic [5:0] reg_idx;
    logic acc;
    logic wr_ctrl;
    logic wr_fault;
    logic mapped;

    assign reg_idx = paddr_i[7:2];
    assign acc = psel_i & penable_i & pready_o;
    assign mapped = (reg_idx == `CP_IDX_CTRL) || (reg_idx == `CP_IDX_STATUS)
        || (reg_idx == `CP_IDX_FAULT);
    assign wr_ctrl = acc & pwrite_i & (reg_idx == `CP_IDX_CTRL);
    assign wr_fault = acc & pwrite_i & (reg_idx == `CP_IDX_FAULT);

    // ----------------------------------------
    // control register
    // ----------------------------------------
    logic [1:0] ctrl;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            ctrl <= `CP_CTRL_RESET;
        else if (wr_ctrl)
            ctrl <= pwdata_i[1:0];
    end

    // ----------------------------------------
    // fault flags, set wins over clear
    // ----------------------------------------
    logic [2:0] fault;
    logic [2:0] fault_set;
    logic [2:0] fault_clr;
    logic short_event;

    assign fault_clr = wr_fault ? pwdata_i[2:0] : 3'h0;
    assign fault_set[`CP_FLT_TSD] = cmp.die_over_shutdown;
    assign fault_set[`CP_FLT_WARN] = cmp.die_over_warning;
    assign fault_set[`CP_FLT_SHORT] = short_event;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            fault <= 3'h0;
        else
            fault <= fault_set | (fault & ~fault_clr);
    end

    // charger stays down until cool and flag clear
    logic hot_hold;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            hot_hold <= 1'b0;
        else if (cmp.die_over_shutdown)
            hot_hold <= 1'b1;
        else if (cmp.die_below_falling && !fault[`CP_FLT_TSD])
            hot_hold <= 1'b0;
    end

    // ----------------------------------------
    // detection and charge sequence
    // ----------------------------------------
    charger_protection_pkg::chg_state_t state;
    charger_protection_pkg::chg_state_t next_state;
    logic [31:0] phase_cnt;
    logic [39:0] trk_cnt;
    logic det_done;
    logic short_done;
    logic trk_done;
    logic recover;

    assign det_done = phase_cnt >= 32'(DET_CYCLES - 1);
    assign short_done = phase_cnt >= 32'(SHORT_CYCLES - 1);
    assign trk_done = trk_cnt >= 40'(TRICKLE_CYCLES - 1);
    assign recover = wr_fault && (pwdata_i[2:0] != 3'h0);
    assign short_event = (state == charger_protection_pkg::ST_TRICKLE)
        && short_done && !cmp.bat_over_short;

    always_comb
    begin
        next_state = state;
        case (state)
            charger_protection_pkg::ST_IDLE:
                next_state = charger_protection_pkg::ST_SINK;
            charger_protection_pkg::ST_SINK:
                if (det_done)
                    next_state = cmp.bat_below_low ? charger_protection_pkg::ST_SOURCE
                        : charger_protection_pkg::ST_CHARGE;
            charger_protection_pkg::ST_SOURCE:
                if (cmp.bat_over_high)
                    next_state = charger_protection_pkg::ST_NO_BATT;
                else if (det_done)
                    next_state = charger_protection_pkg::ST_TRICKLE;
            charger_protection_pkg::ST_NO_BATT:
                next_state = charger_protection_pkg::ST_NO_BATT;
            charger_protection_pkg::ST_TRICKLE:
                if (short_event)
                    next_state = charger_protection_pkg::ST_SHORT;
                else if (trk_done)
                    next_state = charger_protection_pkg::ST_FAULT;
                else if (cmp.bat_over_dead)
                    next_state = charger_protection_pkg::ST_CHARGE;
            charger_protection_pkg::ST_SHORT:
                if (trk_done)
                    next_state = charger_protection_pkg::ST_FAULT;
            charger_protection_pkg::ST_CHARGE:
                next_state = charger_protection_pkg::ST_CHARGE;
            charger_protection_pkg::ST_FAULT:
                if (recover)
                    next_state = charger_protection_pkg::ST_IDLE;
            default:
                next_state = charger_protection_pkg::ST_IDLE;
        endcase
        if (!cmp.input_valid)
            next_state = charger_protection_pkg::ST_IDLE;
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            state <= charger_protection_pkg::ST_IDLE;
        else if (!cmp.input_valid || !hot_hold || state == charger_protection_pkg::ST_FAULT)
            state <= next_state;
    end

    // phase counter restarts on every state change
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || next_state != state)
            phase_cnt <= 32'h0;
        else if (!(det_done && short_done))
            phase_cnt <= phase_cnt + 32'h1;
    end

    // trickle timer runs through trickle and short
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            trk_cnt <= 40'h0;
        else if (state != charger_protection_pkg::ST_TRICKLE
            && state != charger_protection_pkg::ST_SHORT)
            trk_cnt <= 40'h0;
        else if (!trk_done)
            trk_cnt <= trk_cnt + 40'h1;
    end

    // ----------------------------------------
    // thermistor excitation
    // ----------------------------------------
    logic [31:0] thr_cnt;
    logic thr_active;
    logic thr_window;
    logic thr_sample;
    logic pack_bad;

    assign thr_active = cmp.input_over_4v0 ? 1'b1
        : (cmp.bat_over_2v5 & ctrl[`CP_CTRL_THR_EN]);
    assign thr_window = thr_active && (thr_cnt < 32'(THR_ON_CYCLES));
    assign thr_sample = thr_active && (thr_cnt == 32'(THR_ON_CYCLES - 1));

    always_ff @(posedge mclk_i)
    begin
        if (srst_i || !thr_active || thr_cnt >= 32'(THR_PERIOD_CYCLES - 1))
            thr_cnt <= 32'h0;
        else
            thr_cnt <= thr_cnt + 32'h1;
    end

    // an open pin shows as cold at the comparator
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || !thr_active)
            pack_bad <= 1'b0;
        else if (thr_sample)
            pack_bad <= cmp.pack_cold | cmp.pack_hot;
    end

    // ----------------------------------------
    // isolation switch mode
    // ----------------------------------------
    charger_protection_pkg::iso_mode_t next_iso;

    always_comb
    begin
        if (!cmp.input_valid)
            next_iso = charger_protection_pkg::ISO_FULL;
        else if (state == charger_protection_pkg::ST_SHORT)
            next_iso = charger_protection_pkg::ISO_OFF;
        else if (cmp.sys_below_bat)
            next_iso = charger_protection_pkg::ISO_FULL;
        else if (state == charger_protection_pkg::ST_TRICKLE)
            next_iso = charger_protection_pkg::ISO_OFF;
        else if (cmp.bat_over_sysreg)
            next_iso = charger_protection_pkg::ISO_FULL;
        else if (cmp.bat_over_dead)
            next_iso = charger_protection_pkg::ISO_REGULATE;
        else
            next_iso = charger_protection_pkg::ISO_OFF;
    end

    // ----------------------------------------
    // analog drives
    // ----------------------------------------
    charger_protection_pkg::drive_t next_drive;
    logic chg_allowed;

    assign chg_allowed = !hot_hold && !pack_bad && ctrl[`CP_CTRL_CHG_EN];

    always_comb
    begin
        next_drive.charge_enable = chg_allowed
            && (state == charger_protection_pkg::ST_CHARGE
            || state == charger_protection_pkg::ST_TRICKLE
            || state == charger_protection_pkg::ST_SHORT);
        next_drive.trickle_enable = chg_allowed
            && (state == charger_protection_pkg::ST_TRICKLE
            || state == charger_protection_pkg::ST_SHORT);
        next_drive.sink_enable = (state == charger_protection_pkg::ST_SINK);
        next_drive.source_enable = (state == charger_protection_pkg::ST_SOURCE);
        next_drive.thr_source = thr_window;
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            drive_o <= '0;
            iso_mode_o <= charger_protection_pkg::ISO_FULL;
        end
        else
        begin
            drive_o <= next_drive;
            iso_mode_o <= next_iso;
        end
    end

    // ----------------------------------------
    // status and read data
    // ----------------------------------------
    logic [2:0] chg_code;
    logic [31:0] status_word;

    always_comb
    begin
        case (state)
            charger_protection_pkg::ST_SINK: chg_code = `CP_CHG_DETECT;
            charger_protection_pkg::ST_SOURCE: chg_code = `CP_CHG_DETECT;
            charger_protection_pkg::ST_NO_BATT: chg_code = `CP_CHG_NO_BATT;
            charger_protection_pkg::ST_TRICKLE: chg_code = `CP_CHG_TRICKLE;
            charger_protection_pkg::ST_SHORT: chg_code = `CP_CHG_SHORT;
            charger_protection_pkg::ST_CHARGE: chg_code = `CP_CHG_FAST;
            charger_protection_pkg::ST_FAULT: chg_code = `CP_CHG_FAULT;
            default: chg_code = `CP_CHG_OFF;
        endcase
    end

    always_comb
    begin
        status_word = 32'h0;
        status_word[`CP_ST_ISO_LSB +: 2] = iso_mode_o;
        status_word[`CP_ST_CHG_LSB +: 3] = chg_code;
        status_word[`CP_ST_THR_ACT] = thr_active;
        status_word[`CP_ST_PACK_BAD] = pack_bad;
        status_word[`CP_ST_HOLD] = hot_hold;
        status_word[`CP_ST_NTC_100K] = NTC_100K;
        status_word[`CP_ST_BETA_LSB +: 3] = BETA_SEL;
    end

    assign rd_word = (reg_idx == `CP_IDX_CTRL) ? {30'h0, ctrl}
        : (reg_idx == `CP_IDX_FAULT) ? {29'h0, fault}
        : (reg_idx == `CP_IDX_STATUS) ? status_word
        : 32'h0;

    // one wait state, answer in second access cycle
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o <= psel_i & penable_i & ~pready_o;
            prdata_o <= (psel_i & penable_i & ~pready_o & ~pwrite_i) ? rd_word : 32'h0;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
        end
    end

endmodule : charger_protection_control

// ---- dv/charger_protection_props.sv ----
`timescale 1ns/100ps
module charger_protection_props #(
    parameter int unsigned DET_CYCLES = 8
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // analog side
    input wire charger_protection_pkg::cmp_t cmp_i,
    input wire charger_protection_pkg::drive_t drive_o,
    input wire charger_protection_pkg::iso_mode_t iso_mode_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // ----
    // sink phase length
    // ----
    int unsigned sink_cnt;
    always_ff @(posedge mclk_i)
    begin
        sink_cnt <= (srst_i || !drive_o.sink_enable) ? 32'd0 : sink_cnt + 32'd1;
    end
    sequence apb_setup;
        psel_i && !penable_i;
    endsequence
    sequence apb_access;
        psel_i && penable_i;
    endsequence
    apb_wait_a: assert property (apb_setup ##1 apb_access |=> pready_o)
        else $error("apb answer late");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    err_resp_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("error response malformed");
    tsd_off_a: assert property (cmp_i.die_over_shutdown [*8] |-> !drive_o.charge_enable)
        else $error("charger on while over shutdown");
    nin_full_a: assert property (!cmp_i.input_valid [*8] |->
        iso_mode_o == charger_protection_pkg::ISO_FULL)
        else $error("switch not full without input");
    trk_off_a: assert property ((!cmp_i.sys_below_bat && cmp_i.input_valid) [*8]
        ##0 drive_o.trickle_enable |->
        iso_mode_o == charger_protection_pkg::ISO_OFF)
        else $error("switch not off in trickle");
    sys_full_a: assert property (cmp_i.sys_below_bat [*8] |->
        iso_mode_o == charger_protection_pkg::ISO_FULL)
        else $error("switch not full with system low");
    sink_len_a: assert property (drive_o.sink_enable |-> sink_cnt <= DET_CYCLES)
        else $error("sink phase too long");
    phase_mutex_a: assert property (!(drive_o.sink_enable && drive_o.source_enable))
        else $error("sink and source together");
    thr_gate_a: assert property ((!cmp_i.input_over_4v0 && !cmp_i.bat_over_2v5) [*8] |->
        !drive_o.thr_source)
        else $error("thermistor source on while gated");
endmodule : charger_protection_props
bind charger_protection_control charger_protection_props #(.DET_CYCLES(DET_CYCLES)) u_props (
    .mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_i(cmp_i), .drive_o(drive_o),
    .iso_mode_o(iso_mode_o)
);

// ---- dv/charger_analog_model.sv ----
`timescale 1ns/100ps
module charger_analog_model (
    // clock
    input wire logic mclk_i,
    // levels from bench and device
    input wire charger_protection_pkg::cmp_t base_i,
    input wire logic no_batt_i,
    input wire charger_protection_pkg::drive_t drive_i,
    // comparator levels
    output charger_protection_pkg::cmp_t cmp_o
);
    logic [2:0] src_cnt;
    logic node_high;
    // empty node charges up under source current
    assign node_high = no_batt_i && (src_cnt == 3'h1);
    always_ff @(posedge mclk_i)
    begin
        src_cnt <= !drive_i.source_enable ? 3'h0 : (node_high ? src_cnt : src_cnt + 3'h1);
    end
    always_comb
    begin
        cmp_o = base_i;
        cmp_o.bat_over_high = base_i.bat_over_high | node_high;
    end
endmodule : charger_analog_model

// ---- dv/charger_protection_control_bench.sv ----
`timescale 1ns/100ps
module charger_protection_control_bench;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    charger_protection_pkg::cmp_t base = '0;
    charger_protection_pkg::cmp_t cmp_i;
    charger_protection_pkg::drive_t drive_o;
    charger_protection_pkg::iso_mode_t iso_mode_o;
    logic no_batt = 1'b0;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int n_compared = 0;
    always #50 mclk_i = ~mclk_i;
    charger_protection_control #(.DET_CYCLES(8), .SHORT_CYCLES(20), .THR_PERIOD_CYCLES(40),
        .THR_ON_CYCLES(4), .TRICKLE_CYCLES(64'd60)) uut (
        .mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_i(cmp_i), .drive_o(drive_o),
        .iso_mode_o(iso_mode_o));
    charger_analog_model model (.mclk_i(mclk_i), .base_i(base), .no_batt_i(no_batt),
        .drive_i(drive_o), .cmp_o(cmp_i));
    // ----
    // common tasks
    // ----
    task automatic conclude;
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n == 20)
        begin
            err_total++;
            conclude();
        end
        @(posedge mclk_i);
    endtask : apb
    task automatic poll(input logic [2:0] code);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, 8'h2C, 32'h0);
            n++;
        end
        while (rd[4:2] !== code && n < 50);
        chk(32'(rd[4:2]), 32'(code));
    endtask : poll
    task automatic settle;
        repeat (8) @(posedge mclk_i);
    endtask : settle
    task automatic plug(input logic low, input logic nb);
        base.input_valid <= 1'b0;
        settle();
        base.bat_below_low <= low;
        no_batt <= nb;
        base.input_valid <= 1'b1;
        @(posedge mclk_i);
    endtask : plug
    // ----
    // scenarios
    // ----
    task automatic t_regs;
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, 8'h2C, 32'hFFF);
        apb(1'b0, 8'h2C, 32'h0);
        chk(rd, 32'h2);
        base.bat_over_2v5 <= 1'b1;
        settle();
        apb(1'b0, 8'h2C, 32'h0);
        chk(32'(rd[5]), 32'h0);
        apb(1'b1, 8'h1C, 32'h3);
        apb(1'b0, 8'h2C, 32'h0);
        chk(32'(rd[5]), 32'h1);
    endtask : t_regs
    task automatic t_detect;
        int n;
        int rises;
        int highs;
        logic prev;
        plug(1'b0, 1'b0);
        for (n = 0; n < 20 && drive_o.sink_enable !== 1'b1; n++)
            @(posedge mclk_i);
        chk(32'(drive_o.sink_enable), 32'h1);
        poll(3'h2);
        chk(32'(drive_o.charge_enable), 32'h1);
        base.input_over_4v0 <= 1'b1;
        for (n = 0; n < 2; n++)
        begin
            base.pack_cold <= (n == 0);
            base.pack_hot <= (n == 1);
            repeat (100) @(posedge mclk_i);
            chk(32'(drive_o.charge_enable), 32'h0);
            apb(1'b0, 8'h2C, 32'h0);
            chk(32'(rd[6]), 32'h1);
        end
        base.pack_hot <= 1'b0;
        repeat (100) @(posedge mclk_i);
        chk(32'(drive_o.charge_enable), 32'h1);
        rises = 0;
        highs = 0;
        prev = drive_o.thr_source;
        repeat (40)
        begin
            @(posedge mclk_i);
            rises += int'(drive_o.thr_source && !prev);
            highs += int'(drive_o.thr_source);
            prev = drive_o.thr_source;
        end
        chk(32'(rises), 32'h1);
        chk(32'(highs), 32'h4);
    endtask : t_detect
    task automatic t_thermal;
        base.die_over_warning <= 1'b1;
        base.die_over_shutdown <= 1'b1;
        settle();
        chk(32'(drive_o.charge_enable), 32'h0);
        apb(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 8'h2C, 32'h0);
        chk(32'(rd[7]), 32'h1);
        base.die_over_warning <= 1'b0;
        base.die_over_shutdown <= 1'b0;
        base.die_below_falling <= 1'b1;
        settle();
        chk(32'(drive_o.charge_enable), 32'h0);
        apb(1'b1, 8'h34, 32'h1);
        settle();
        chk(32'(drive_o.charge_enable), 32'h1);
        apb(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, 8'h34, 32'h2);
        apb(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h0);
    endtask : t_thermal
    task automatic t_short;
        plug(1'b1, 1'b1);
        poll(3'h4);
        plug(1'b1, 1'b0);
        poll(3'h1);
        chk(32'(iso_mode_o), 32'h0);
        poll(3'h5);
        chk(32'(iso_mode_o), 32'h0);
        chk(32'(drive_o.trickle_enable), 32'h1);
        apb(1'b0, 8'h34, 32'h0);
        chk(32'(rd[2]), 32'h1);
        poll(3'h6);
        apb(1'b1, 8'h34, 32'h7);
        poll(3'h3);
    endtask : t_short
    task automatic t_iso;
        plug(1'b1, 1'b0);
        poll(3'h1);
        base.input_valid <= 1'b0;
        settle();
        chk(32'(iso_mode_o), 32'h2);
        plug(1'b1, 1'b0);
        poll(3'h1);
        base.bat_over_dead <= 1'b1;
        poll(3'h2);
        chk(32'(iso_mode_o), 32'h1);
        base.sys_below_bat <= 1'b1;
        settle();
        chk(32'(iso_mode_o), 32'h2);
        base.sys_below_bat <= 1'b0;
        settle();
        chk(32'(iso_mode_o), 32'h1);
        base.bat_over_sysreg <= 1'b1;
        settle();
        chk(32'(iso_mode_o), 32'h2);
    endtask : t_iso
    initial
    begin
        repeat (12) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        t_regs();
        t_detect();
        t_thermal();
        t_short();
        t_iso();
        conclude();
    end
endmodule : charger_protection_control_bench
